// ==== hdl/cfg_header_regs.sv ====
// Configuration header registers: identity, line size, latency, BARs
`timescale 1ns/1ps
`include "cfg_header_params.svh"

// Summary of operation
// - Eight-bit read-only revision; low three bits may come from EEPROM.
// - Class code reads network controller, Ethernet subclass, interface zero.
// - Line size accepts only 8 or 16; otherwise write-invalidate disabled.
// - After an invalid line size write the register reads zero.
// - Bit 3 set only by writing 8, bit 4 only by 16.
// - Latency timer limits bus ownership cycles while bus master.
// - Header type reads 00H single function, 80H combo card.
// - Combo card second function is reached at config offset 100H.
// - All base registers 32 bits; bit 0 zero memory, one I/O, except option ROM bit 0 (enable).
// - I/O base bit 1 reads zero; upper bits hold I/O base.
// - Only window-sized upper bits writable; lower address bits read zero.
// - CSR memory base claims non-prefetchable 4 Kbyte 32-bit window.
// - CSR I/O base claims a 64 byte I/O window.
// - Flash base always claims a 128 Kbyte memory window.
// - Option ROM base claims 1 Mbyte backed by local bus memory.
// - With ROM suppress set, option ROM base reads all zero.
// - First ROM access on a combo card drives modem select; ROM suppress clears after first ROM access.
// - Modem select high before first ROM access, low afterwards on combo cards only.
// - Revision low bits load only with signature 01b and select 1b.
// - Config cycles are retried until the EEPROM read completes.
module cfg_header_regs #(
  parameter logic [7:0] REV_DEFAULT = 8'h5A  // Arbitrary revision value
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_ce,
  input  wire cfg_header_pkg::cfg_req_t i_cfg_req,
  output cfg_header_pkg::cfg_rsp_t      o_cfg_rsp,
  input  wire logic                     i_ee_done,
  input  wire logic [15:0]              i_ee_word,
  input  wire logic                     i_bus_owned,
  input  wire logic                     i_rom_access,
  input  wire logic                     i_space_io,
  input  wire logic [31:0]              i_space_addr,
  output logic                          o_csr_hit,
  output logic                          o_flash_hit,
  output logic                          o_rom_hit,
  output logic                          o_mwi_allowed,
  output logic [7:0]                    o_line_size,
  output logic                          o_tenure_expired,
  output logic                          o_modem_chip_select_n,
  output cfg_header_pkg::bar_set_t      o_bars
);
  import cfg_header_pkg::*;

  // ***************************************
  // Reset release and functions
  // ***************************************
  logic [1:0]  rst_sync;
  logic        rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  function automatic logic bar_match(input logic [31:0] addr,
                                     input logic [31:0] base,
                                     input logic [31:0] mask);
    return ((addr ^ base) & mask) == 32'h0;
  endfunction

  // ***************************************
  // EEPROM presets
  // ***************************************
  logic        ee_loaded;
  logic [2:0]  rev_low;
  logic        combo;
  logic        rom_suppress;
  logic        rom_handed_off;
  logic        ee_valid;

  assign ee_valid = i_ee_word[`EE_SIG_HI:`EE_SIG_LO] == `EE_SIG_VALID;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ee_loaded <= 1'b0;
      rev_low   <= 3'h0;
      combo     <= 1'b0;
    end else if (i_ce && i_ee_done && !ee_loaded) begin
      ee_loaded <= 1'b1;
      rev_low   <= (ee_valid && i_ee_word[`EE_IDENT_SEL])
                   ? i_ee_word[`EE_REV_HI:`EE_REV_LO]
                   : REV_DEFAULT[2:0];
      combo     <= ee_valid && i_ee_word[`EE_COMBO_BIT];
    end
  end

  // suppress cleared by first ROM access
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_suppress   <= 1'b0;
      rom_handed_off <= 1'b0;
    end else if (i_ce) begin
      if (i_ee_done && !ee_loaded) begin
        rom_suppress <= ee_valid && i_ee_word[`EE_BOOT_DISABLE];
      end else if (i_rom_access) begin
        rom_suppress <= 1'b0;
      end
      if (i_rom_access && combo) begin
        rom_handed_off <= 1'b1;
      end
    end
  end

  // modem owns local bus after hand-off
  assign o_modem_chip_select_n = !rom_handed_off;

  // ***************************************
  // Writable registers
  // ***************************************
  logic [7:0]  line_size_reg;
  logic [7:0]  latency_timer;
  bar_set_t    bars;
  logic        wr_take;
  logic [8:0]  req_ofs;
  logic [31:0] wd;

  assign req_ofs = {i_cfg_req.addr, 2'b00};
  assign wd      = i_cfg_req.wdata;
  assign wr_take = i_ce && i_cfg_req.valid && i_cfg_req.write && ee_loaded;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_size_reg <= 8'h00;
      latency_timer <= 8'h00;
    end else if (wr_take && req_ofs == `OFS_LINE_HDR) begin
      if (i_cfg_req.be[0]) begin
        line_size_reg <= (wd[7:0] == `LINE_SIZE_8 ||
                          wd[7:0] == `LINE_SIZE_16) ? wd[7:0] : 8'h00;
      end
      if (i_cfg_req.be[1]) begin
        latency_timer <= wd[15:8];
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      bars <= '{csr_mem: `TYPE_MEM, csr_io: `TYPE_IO,
                flash: `TYPE_MEM, option_rom: `TYPE_MEM};
    end else if (wr_take) begin
      unique case (req_ofs)
        `OFS_CSR_MEM: bars.csr_mem <=
          (merge_be(bars.csr_mem, wd, i_cfg_req.be) & `MASK_CSR_MEM)
          | `TYPE_MEM;
        `OFS_CSR_IO: bars.csr_io <=
          (merge_be(bars.csr_io, wd, i_cfg_req.be) & `MASK_CSR_IO)
          | `TYPE_IO;
        `OFS_FLASH: bars.flash <=
          (merge_be(bars.flash, wd, i_cfg_req.be) & `MASK_FLASH)
          | `TYPE_MEM;
        `OFS_OPTION_ROM: bars.option_rom <=
          merge_be(bars.option_rom, wd, i_cfg_req.be)
          & (`MASK_OPTION_ROM | 32'h0000_0001);
        default: ;
      endcase
    end
  end

  assign o_bars        = bars;
  assign o_line_size   = line_size_reg;
  assign o_mwi_allowed = line_size_reg != 8'h00;

  // ***************************************
  // Address decode and latency timer
  // ***************************************
  // both CSR paths decoded
  assign o_csr_hit = i_space_io
    ? bar_match(i_space_addr, bars.csr_io, `MASK_CSR_IO)
    : bar_match(i_space_addr, bars.csr_mem, `MASK_CSR_MEM);
  assign o_flash_hit = !i_space_io
    && bar_match(i_space_addr, bars.flash, `MASK_FLASH);
  assign o_rom_hit = !i_space_io && !rom_suppress
    && bars.option_rom[`ROM_ENABLE_BIT]
    && bar_match(i_space_addr, bars.option_rom, `MASK_OPTION_ROM);

  logic [7:0] tenure_count;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tenure_count <= 8'h00;
    end else if (i_ce) begin
      if (!i_bus_owned) begin
        tenure_count <= 8'h00;
      end else if (tenure_count != latency_timer) begin
        tenure_count <= tenure_count + 8'h01;
      end
    end
  end
  assign o_tenure_expired = i_bus_owned && tenure_count == latency_timer;

  // ***************************************
  // Read data and response
  // ***************************************
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0;
    unique case (req_ofs)
      `OFS_REV_CLASS: next_rdata = {`CLASS_BASE, `CLASS_SUB,
                                    `CLASS_PROG_IF,
                                    REV_DEFAULT[7:3], rev_low};
      `OFS_LINE_HDR: next_rdata = {8'h00,
                                   combo ? `HDR_COMBO : `HDR_SINGLE,
                                   latency_timer, line_size_reg};
      `OFS_CSR_MEM:  next_rdata = bars.csr_mem;
      `OFS_CSR_IO:   next_rdata = bars.csr_io;
      `OFS_FLASH:    next_rdata = bars.flash;
      `OFS_OPTION_ROM: next_rdata = rom_suppress ? 32'h0 : bars.option_rom;
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cfg_rsp <= '0;
    end else if (i_ce) begin
      o_cfg_rsp.ack       <= 1'b0;
      o_cfg_rsp.retry     <= 1'b0;
      o_cfg_rsp.func2_sel <= 1'b0;
      if (i_cfg_req.valid) begin
        if (!ee_loaded) begin
          o_cfg_rsp.retry <= 1'b1;
        end else if (combo && i_cfg_req.addr[8]) begin
          o_cfg_rsp.func2_sel <= 1'b1;
        end else begin
          o_cfg_rsp.ack   <= 1'b1;
          o_cfg_rsp.rdata <= i_cfg_req.addr[8] ? 32'h0 : next_rdata;
        end
      end
    end
  end

  // ***************************************
  // Checks
  // ***************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  chk_retry_early: assert property (
    i_ce && i_cfg_req.valid && !ee_loaded |=> o_cfg_rsp.retry
      && !o_cfg_rsp.ack) else $error("config access not retried");
  chk_line_valid: assert property (
    line_size_reg == 8'h00 || line_size_reg == `LINE_SIZE_8
      || line_size_reg == `LINE_SIZE_16) else $error("bad line size");
  chk_line_reject: assert property (
    wr_take && req_ofs == `OFS_LINE_HDR && i_cfg_req.be[0]
      && wd[7:0] != `LINE_SIZE_8 && wd[7:0] != `LINE_SIZE_16
      |=> line_size_reg == 8'h00 && !o_mwi_allowed)
    else $error("invalid line size kept");
  chk_io_type: assert property (
    bars.csr_io[1:0] == 2'b01 && bars.csr_mem[11:0] == 12'h0)
    else $error("base type bits wrong");
  chk_size_mask: assert property (
    wr_take && req_ofs == `OFS_FLASH && wd == 32'hFFFF_FFFF
      && i_cfg_req.be == 4'hF |=> bars.flash == `MASK_FLASH)
    else $error("flash size mask wrong");
  chk_rom_zero: assert property (
    i_ce && i_cfg_req.valid && ee_loaded && rom_suppress
      && req_ofs == `OFS_OPTION_ROM
      |=> o_cfg_rsp.rdata == 32'h0) else $error("suppressed ROM visible");
  chk_modem_select: assert property (
    i_ce && i_rom_access && combo |=> !o_modem_chip_select_n
      ##1 !o_modem_chip_select_n) else $error("modem select not low");
  chk_suppress_clr: assert property (
    i_ce && i_rom_access && ee_loaded |=> !rom_suppress)
    else $error("suppress not cleared");
  chk_header_type: assert property (
    i_ce && i_cfg_req.valid && ee_loaded && req_ofs == `OFS_LINE_HDR
      |=> o_cfg_rsp.rdata[23:16] == (combo ? `HDR_COMBO : `HDR_SINGLE))
    else $error("header type wrong");
  chk_tenure: assert property (
    i_bus_owned && tenure_count != latency_timer && i_ce
      |=> !i_bus_owned || tenure_count == $past(tenure_count) + 8'h01)
    else $error("tenure count stalled");

  cov_retry: cover property (o_cfg_rsp.retry);
  cov_func2: cover property (o_cfg_rsp.func2_sel);
  cov_handoff: cover property ($fell(o_modem_chip_select_n));
  cov_expire: cover property (o_tenure_expired);
endmodule

// ==== pkg/cfg_header_params.svh ====
// Offsets, field positions, masks and reset values of the config header
`ifndef CFG_HEADER_PARAMS_SVH
`define CFG_HEADER_PARAMS_SVH

// Byte offsets of the header dwords
`define OFS_REV_CLASS    9'h008
`define OFS_LINE_HDR     9'h00C
`define OFS_CSR_MEM      9'h010
`define OFS_CSR_IO       9'h014
`define OFS_FLASH        9'h018
`define OFS_OPTION_ROM   9'h030
`define OFS_FUNC2        9'h100

// Class code bytes
`define CLASS_BASE       8'h02
`define CLASS_SUB        8'h00
`define CLASS_PROG_IF    8'h00

// Accepted line sizes in dwords
`define LINE_SIZE_8      8'h08
`define LINE_SIZE_16     8'h10

// Header type values
`define HDR_SINGLE       8'h00
`define HDR_COMBO        8'h80

// Writable address bits of each base register (size masks)
`define MASK_CSR_MEM     32'hFFFF_F000
`define MASK_CSR_IO      32'hFFFF_FFC0
`define MASK_FLASH       32'hFFFE_0000
`define MASK_OPTION_ROM  32'hFFF0_0000

// Read-only type bits of the base registers, and the writable ROM enable bit
`define TYPE_MEM         32'h0000_0000
`define TYPE_IO          32'h0000_0001
`define ROM_ENABLE_BIT   0

// Fields of EEPROM control word
`define EE_SIG_HI        15
`define EE_SIG_LO        14
`define EE_SIG_VALID     2'h1
`define EE_IDENT_SEL     13
`define EE_BOOT_DISABLE  11
`define EE_REV_HI        10
`define EE_REV_LO        8
`define EE_COMBO_BIT     0

`endif

// ==== pkg/cfg_header_pkg.sv ====
// Types shared by the configuration header register bank
package cfg_header_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [8:2]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic        retry;
    logic        func2_sel;
    logic [31:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic [31:0] csr_mem;
    logic [31:0] csr_io;
    logic [31:0] flash;
    logic [31:0] option_rom;
  } bar_set_t;

endpackage

// ==== testbench/cfg_header_regs_tb_top.sv ====
// Self-checking bench for the configuration header register bank
`timescale 1ns/1ps
`include "cfg_header_params.svh"
module cfg_header_regs_tb_top;
  import cfg_header_pkg::*;
  typedef struct packed {
    logic [8:0]  ofs;
    logic [3:0]  be;
    logic [31:0] wd;
    logic [31:0] exp;
  } row_t;
  // ****
  // Signals and instances
  // ****
  logic        clk, rst_n, ee_done, owned, rom_acc, sp_io, ce;
  logic        csr_hit, flash_hit, rom_hit, mwi, expired, modem_n;
  logic [15:0] ee_word;
  logic [31:0] sp_addr, d;
  logic [7:0]  line;
  cfg_req_t    req;
  cfg_rsp_t    rsp, r;
  bar_set_t    bars;
  int          err_count, n_tests, k;
  row_t        rows [14] = '{
    '{`OFS_REV_CLASS, 4'hF, 32'hFFFF_FFFF, 32'h0200_005D},
    '{`OFS_LINE_HDR, 4'h3, 32'h0000_FF08, 32'h0000_FF08},
    '{`OFS_LINE_HDR, 4'h3, 32'h0000_2010, 32'h0000_2010},
    '{`OFS_LINE_HDR, 4'h1, 32'h0000_0018, 32'h0000_2000},
    '{`OFS_LINE_HDR, 4'h1, 32'h0000_0009, 32'h0000_2000},
    '{`OFS_LINE_HDR, 4'hF, 32'hFFFF_FF08, 32'h0000_FF08},
    '{`OFS_CSR_MEM, 4'hF, 32'hFFFF_FFFF, 32'hFFFF_F000},
    '{`OFS_CSR_MEM, 4'hF, 32'h1234_5678, 32'h1234_5000},
    '{`OFS_CSR_IO, 4'hF, 32'hFFFF_FFFF, 32'hFFFF_FFC1},
    '{`OFS_CSR_IO, 4'hF, 32'h0000_ABCF, 32'h0000_ABC1},
    '{`OFS_FLASH, 4'hF, 32'hFFFF_FFFF, 32'hFFFE_0000},
    '{`OFS_FLASH, 4'hF, 32'h8001_2345, 32'h8000_0000},
    '{`OFS_OPTION_ROM, 4'hF, 32'hFFFF_FFFF, 32'hFFF0_0001},
    '{`OFS_FUNC2, 4'hF, 32'h0000_0001, 32'h0000_0000}};

  cfg_header_regs dut (
    .i_clk                 (clk),
    .i_rst_n               (rst_n),
    .i_ce                  (ce),
    .i_cfg_req             (req),
    .o_cfg_rsp             (rsp),
    .i_ee_done             (ee_done),
    .i_ee_word             (ee_word),
    .i_bus_owned           (owned),
    .i_rom_access          (rom_acc),
    .i_space_io            (sp_io),
    .i_space_addr          (sp_addr),
    .o_csr_hit             (csr_hit),
    .o_flash_hit           (flash_hit),
    .o_rom_hit             (rom_hit),
    .o_mwi_allowed         (mwi),
    .o_line_size           (line),
    .o_tenure_expired      (expired),
    .o_modem_chip_select_n (modem_n),
    .o_bars                (bars)
  );

  cfg_host_model host (
    .i_clk (clk),
    .o_req (req),
    .i_rsp (rsp)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****
  // Tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [15:0] w);
    @(negedge clk);
    rst_n = 1'b0;
    ee_done = 1'b0;
    ee_word = w;
    repeat (8) @(negedge clk);
    check({31'h0, modem_n}, 32'h1);
    check(bars.csr_io, `TYPE_IO);
    check({24'h0, line}, 32'h0);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    host.xfer(1'b1, `OFS_LINE_HDR, 4'h1, 32'h8, 1, r);
    host.xfer(1'b0, `OFS_REV_CLASS, 4'hF, 32'h0, 1, r);
    check({30'h0, r.ack, r.retry}, 32'h1);
    check({24'h0, line}, 32'h0);
    ee_done = 1'b1;
  endtask

  task automatic wr_rd(input logic [8:0] ofs, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rd);
    host.xfer(1'b1, ofs, be, wd, 4, r);
    host.xfer(1'b0, ofs, 4'hF, 32'h0, 4, r);
    check({31'h0, r.ack}, 32'h1);
    rd = r.rdata;
  endtask

  task automatic hit(input logic io, input logic [31:0] a,
                     input logic [2:0] exp);
    @(negedge clk);
    sp_io = io;
    sp_addr = a;
    #1 check({29'h0, csr_hit, flash_hit, rom_hit}, {29'h0, exp});
  endtask

  task automatic pulse_rom;
    @(negedge clk);
    rom_acc = 1'b1;
    @(negedge clk);
    rom_acc = 1'b0;
    @(negedge clk);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    ee_done = 1'b0;
    ee_word = '0;
    owned = 1'b0;
    rom_acc = 1'b0;
    sp_io = 1'b0;
    sp_addr = '0;
    // Single card, revision low bits 101b from the EEPROM word
    do_reset(16'h6500);
    // line size set here as boot firmware would
    foreach (rows[i]) begin
      wr_rd(rows[i].ofs, rows[i].be, rows[i].wd, d);
      check(d, rows[i].exp);
      if (rows[i].ofs == `OFS_LINE_HDR) begin
        check({24'h0, line}, {24'h0, d[7:0]});
        check({31'h0, mwi}, {31'h0, d[7:0] != 8'h0});
      end
    end
    hit(1'b0, 32'h1234_5FFC, 3'b100);
    hit(1'b0, 32'h1234_6000, 3'b000);
    hit(1'b1, 32'h0000_ABFF, 3'b100);
    hit(1'b1, 32'h0000_AC00, 3'b000);
    hit(1'b0, 32'h0000_ABC0, 3'b000);
    hit(1'b0, 32'h8001_FFFC, 3'b010);
    hit(1'b0, 32'h8002_0000, 3'b000);
    hit(1'b0, 32'hFFFF_FFFC, 3'b001);
    pulse_rom();
    check({31'h0, modem_n}, 32'h1);
    wr_rd(`OFS_LINE_HDR, 4'h2, 32'h0000_0300, d);
    @(negedge clk);
    owned = 1'b1;
    @(negedge clk);
    check({31'h0, expired}, 32'h0);
    k = 0;
    while (expired !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    check(k, 32'h2);
    owned = 1'b0;
    @(negedge clk);
    check({31'h0, expired}, 32'h0);
    // Clock enable low freezes the bank
    ce = 1'b0;
    host.xfer(1'b1, `OFS_LINE_HDR, 4'h1, 32'h0000_0010, 1, r);
    check({31'h0, r.ack}, 32'h0);
    check({24'h0, line}, {24'h0, `LINE_SIZE_8});
    ce = 1'b1;
    // Combo card, identity select clear, ROM suppressed
    do_reset(16'h4F01);
    wr_rd(`OFS_REV_CLASS, 4'hF, 32'h0, d);
    check(d, 32'h0200_005A);
    wr_rd(`OFS_LINE_HDR, 4'h1, 32'h0000_0010, d);
    check({24'h0, d[23:16]}, {24'h0, `HDR_COMBO});
    host.xfer(1'b0, `OFS_FUNC2, 4'hF, 32'h0, 4, r);
    check({30'h0, r.func2_sel, r.ack}, 32'h2);
    wr_rd(`OFS_OPTION_ROM, 4'hF, 32'hFFFF_FFFF, d);
    check(d, 32'h0);
    check({31'h0, modem_n}, 32'h1);
    hit(1'b0, 32'hFFFF_FFFC, 3'b000);
    pulse_rom();
    check({31'h0, modem_n}, 32'h0);
    wr_rd(`OFS_OPTION_ROM, 4'hF, 32'hFFFF_FFFF, d);
    check(d, 32'hFFF0_0001);
    hit(1'b0, 32'hFFFF_FFFC, 3'b001);
    end_of_test();
  end

  initial begin
    #4_000_000;
    err_count++;
    end_of_test();
  end
endmodule

// ==== testbench/cfg_host_model.sv ====
// Host-side configuration master model for the header register bank
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic                     i_clk,
  output cfg_header_pkg::cfg_req_t      o_req,
  input  wire cfg_header_pkg::cfg_rsp_t i_rsp
);
  import cfg_header_pkg::*;

  initial o_req = '0;

  task automatic xfer(input logic wr, input logic [8:0] ofs,
                      input logic [3:0] be, input logic [31:0] wd,
                      input int tries, output cfg_rsp_t rsp);
    rsp = '0;
    for (int i = 0; i < tries; i++) begin
      @(negedge i_clk);
      o_req <= '{1'b1, wr, ofs[8:2], be, wd};
      @(negedge i_clk);
      // Answer pulse stands for the cycle after the taking edge
      rsp = i_rsp;
      // Released lines do not keep the last value
      o_req <= '{1'b0, ~wr, ~ofs[8:2], ~be, ~wd};
      if (!rsp.retry) begin
        break;
      end
    end
  endtask
endmodule
